// [shared/wdt_pkg.sv]
/*
  package for the watchdog and periodic tick block: register offsets,
  field positions, reset values, service values and timing counts.
  assumes a 32-bit apb slave with word-aligned registers.
*/
`default_nettype none
package wdt_pkg;

  // register byte offsets
  localparam logic [7:0] watchdog_control_off      = 8'h00;
  localparam logic [7:0] watchdog_arm_register_off = 8'h04;
  localparam logic [7:0] periodic_rate_control_off = 8'h08;
  localparam logic [7:0] status_off                = 8'h0c;
  localparam logic [7:0] mask_off                  = 8'h10;
  localparam logic [7:0] state_off                 = 8'h14;

  // watchdog_control fields
  localparam int rate_lsb        = 0;
  localparam int window_bit      = 3;
  localparam int pstop_bit       = 4;
  localparam int ctl_width       = 5;

  // status and mask fields
  localparam int periodic_flag_bit = 0;
  localparam int wd_reset_bit      = 1;
  localparam int stat_width        = 2;

  localparam logic [4:0]  watchdog_control_rst      = 5'h00;
  localparam logic [7:0]  periodic_rate_control_rst = 8'h00;
  localparam logic [1:0]  status_rst                = 2'h0;
  localparam logic [1:0]  mask_rst                  = 2'h0;

  localparam logic [15:0] service_first  = 16'h0055;
  localparam logic [15:0] service_second = 16'h00aa;

  // oscillator gate: one oscillator tick every osc_div_last + 1 mclk cycles
  localparam logic [3:0]  osc_div_last   = 4'h3;

  // watchdog period is 2 ** (wd_base + rate) oscillator ticks
  localparam int wd_base = 7;
  // periodic period is (low nibble + 1) << (bits 6:4 + tick_base)
  localparam int tick_base = 3;

  // length of the system reset pulse in mclk cycles
  localparam logic [3:0]  sysrst_len     = 4'hf;

  typedef struct packed {
    logic       pstop_count;
    logic       window_mode;
    logic [2:0] rate;
  } watchdog_control_t;

  typedef struct packed {
    logic wd_reset;
    logic periodic_flag;
  } status_t;

endpackage : wdt_pkg
`default_nettype wire

// [logic/watchdog_and_periodic_tick.sv]
/*
  watchdog with windowed service and periodic tick timer, apb slave.
  assumes a single 100 mhz mclk; the oscillator clock is modelled as a
  one-cycle enable from a divider; pseudo_stop comes from the power
  controller on the same clock.
*/
// Behaviour
// - watchdog is disabled after reset until software writes its rate
// - enabled watchdog expiring without service starts a system reset
// - watchdog advances on the gated oscillator enable, not every mclk
// - three-bit rate field selects one of seven watchdog periods
// - writing first then second service value restarts the period
// - any other value written to the arm register while the watchdog is enabled resets the part
// - window mode accepts service only in the last quarter of period
// - window mode service before the last quarter resets the part
// - with pseudo-stop count enable the watchdog runs in pseudo-stop
// - tick timer counts gated oscillator ticks at programmed rate
// - tick period end sets periodic flag and restarts automatically
// - tick interrupt only raised when periodic interrupt enable is one
// - any write to periodic rate control restarts the tick period
`timescale 1ns/1ps
`default_nettype none
module watchdog_and_periodic_tick (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pseudo_stop,
  output logic             irq,
  output logic             system_reset
);

  typedef enum logic [1:0] {
    arm_idle  = 2'b00,
    arm_first = 2'b01
  } arm_state_t;

  wdt_pkg::watchdog_control_t watchdog_control;
  logic [7:0]                 periodic_rate_control;
  wdt_pkg::status_t           status;
  wdt_pkg::status_t           mask;
  arm_state_t                 arm_state;
  logic [3:0]                 osc_cnt;
  logic                       osc_tick;
  logic [13:0]                wd_cnt;
  logic [17:0]                tick_cnt;
  logic [3:0]                 rst_cnt;

  logic        access;
  logic        wr;
  logic        mapped;
  logic        wd_enabled;
  logic [13:0] wd_last;
  logic        wd_expire;
  logic        in_window;
  logic        arm_wr;
  logic        svc_bad;
  logic        svc_done;
  logic [17:0] tick_last;
  logic        tick_end;
  logic        tick_run;
  logic        trip;

  function automatic logic [13:0] wd_period_last(input logic [2:0] rate);
    wd_period_last = 14'((32'd1 << (wdt_pkg::wd_base + 32'(rate))) - 1);
  endfunction : wd_period_last

  function automatic logic [17:0] tick_period_last(input logic [7:0] r);
    tick_period_last = 18'(((32'(r[3:0]) + 1)
                        << (32'(r[6:4]) + wdt_pkg::tick_base)) - 1);
  endfunction : tick_period_last

  assign access = psel & penable;
  assign wr     = access & pwrite;
  assign pready = 1'b1;
  assign mapped = paddr inside {wdt_pkg::watchdog_control_off,
                                wdt_pkg::watchdog_arm_register_off,
                                wdt_pkg::periodic_rate_control_off,
                                wdt_pkg::status_off, wdt_pkg::mask_off,
                                wdt_pkg::state_off};
  assign pslverr = access & ~mapped;

  // oscillator gate: shared enable for both timers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      osc_cnt <= 4'h0;
    end else if (osc_cnt == wdt_pkg::osc_div_last) begin
      osc_cnt <= 4'h0;
    end else begin
      osc_cnt <= osc_cnt + 4'h1;
    end
  end
  assign osc_tick = (osc_cnt == wdt_pkg::osc_div_last);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      watchdog_control <= wdt_pkg::watchdog_control_rst;
    end else if (wr && paddr == wdt_pkg::watchdog_control_off) begin
      watchdog_control <= pwdata[wdt_pkg::ctl_width-1:0];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mask <= wdt_pkg::mask_rst;
    end else if (wr && paddr == wdt_pkg::mask_off) begin
      mask <= pwdata[wdt_pkg::stat_width-1:0];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      periodic_rate_control <= wdt_pkg::periodic_rate_control_rst;
    end else if (wr && paddr == wdt_pkg::periodic_rate_control_off) begin
      periodic_rate_control <= pwdata[7:0];
    end
  end

  // watchdog
  assign wd_enabled = watchdog_control.rate != 3'h0;
  assign wd_last    = wd_period_last(watchdog_control.rate);
  assign wd_expire  = wd_enabled && osc_tick && wd_cnt == wd_last
                      && (!pseudo_stop || watchdog_control.pstop_count);
  // last quarter starts at three quarters of the period
  assign in_window  = wd_cnt >= (wd_last - (wd_last >> 2));
  assign arm_wr     = wr && paddr == wdt_pkg::watchdog_arm_register_off
                      && wd_enabled;

  always_comb begin
    svc_bad  = 1'b0;
    svc_done = 1'b0;
    if (arm_wr) begin
      if (pwdata[15:0] != wdt_pkg::service_first
          && pwdata[15:0] != wdt_pkg::service_second) begin
        svc_bad = 1'b1;
      end else if (watchdog_control.window_mode && !in_window) begin
        svc_bad = 1'b1;
      end else if (pwdata[15:0] == wdt_pkg::service_second
                   && arm_state == arm_first) begin
        svc_done = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      arm_state <= arm_idle;
    end else if (!wd_enabled || svc_done) begin
      arm_state <= arm_idle;
    end else if (arm_wr && pwdata[15:0] == wdt_pkg::service_first) begin
      arm_state <= arm_first;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wd_cnt <= 14'h0;
    end else if (!wd_enabled || svc_done || trip) begin
      wd_cnt <= 14'h0;
    end else if (osc_tick
                 && (!pseudo_stop || watchdog_control.pstop_count)) begin
      wd_cnt <= wd_cnt + 14'h1;
    end
  end

  assign trip = wd_expire | svc_bad;

  // system reset pulse; a real chip would reset this block as well
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_cnt <= 4'h0;
    end else if (trip) begin
      rst_cnt <= wdt_pkg::sysrst_len;
    end else if (rst_cnt != 4'h0) begin
      rst_cnt <= rst_cnt - 4'h1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      system_reset <= 1'b0;
    end else begin
      system_reset <= trip || rst_cnt > 4'h1;
    end
  end

  // periodic tick
  assign tick_run  = periodic_rate_control[6:4] != 3'h0;
  assign tick_last = tick_period_last(periodic_rate_control);
  assign tick_end  = tick_run && osc_tick && tick_cnt >= tick_last;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt <= 18'h0;
    end else if (wr && paddr == wdt_pkg::periodic_rate_control_off) begin
      tick_cnt <= 18'h0;
    end else if (!tick_run || tick_end) begin
      tick_cnt <= 18'h0;
    end else if (osc_tick) begin
      tick_cnt <= tick_cnt + 18'h1;
    end
  end

  // sticky status; a set in the same cycle as its clear wins
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      status <= wdt_pkg::status_rst;
    end else begin
      if (tick_end) begin
        status.periodic_flag <= 1'b1;
      end else if (wr && paddr == wdt_pkg::status_off
                   && pwdata[wdt_pkg::periodic_flag_bit]) begin
        status.periodic_flag <= 1'b0;
      end
      if (trip) begin
        status.wd_reset <= 1'b1;
      end else if (wr && paddr == wdt_pkg::status_off
                   && pwdata[wdt_pkg::wd_reset_bit]) begin
        status.wd_reset <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        wdt_pkg::watchdog_control_off:
          prdata <= {27'h000_0000, watchdog_control};
        wdt_pkg::periodic_rate_control_off:
          prdata <= {24'h00_0000, periodic_rate_control};
        wdt_pkg::status_off: prdata <= {30'h0000_0000, status};
        wdt_pkg::mask_off:   prdata <= {30'h0000_0000, mask};
        wdt_pkg::state_off:
          prdata <= {17'h0_0000, arm_state == arm_first, wd_cnt};
        default:             prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : watchdog_and_periodic_tick
`default_nettype wire

// [tb/wdt_asserts.sv]
/* port checker for the watchdog and periodic tick block.
   assumes only the ports of that block; bound in after the module. */
`timescale 1ns/1ps
`default_nettype none
module wdt_asserts (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pseudo_stop,
  input wire logic        irq,
  input wire logic        system_reset
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  localparam logic [7:0] arm = wdt_pkg::watchdog_arm_register_off;
  localparam logic [7:0] st  = wdt_pkg::status_off;
  logic       wr;
  logic       acc;
  logic [4:0] ctl;
  logic [1:0] msk;
  assign acc = psel && penable;
  assign wr  = acc && pwrite;
  // shadows of written fields: the ports give no other view of them
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) ctl <= 5'h00;
    else if (wr && paddr == wdt_pkg::watchdog_control_off) ctl <= pwdata[4:0];
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) msk <= 2'h0;
    else if (wr && paddr == wdt_pkg::mask_off) msk <= pwdata[1:0];
  end
  chk_bad_arm: assert property (
    wr && paddr == arm && ctl[2:0] != 3'h0
    && pwdata[15:0] != wdt_pkg::service_first
    && pwdata[15:0] != wdt_pkg::service_second |-> ##[1:2] system_reset)
    else $error("bad arm value did not reset");
  chk_pulse_min: assert property (
    $rose(system_reset) |-> system_reset[*8])
    else $error("reset pulse too short");
  chk_pulse_end: assert property (
    $rose(system_reset) |-> ##[14:20] !system_reset)
    else $error("reset pulse too long");
  chk_off_quiet: assert property (
    ctl[2:0] == 3'h0 && $past(ctl[2:0], 2) == 3'h0 |-> !$rose(system_reset))
    else $error("reset while watchdog off");
  chk_ctl_read: assert property (
    acc && !pwrite && paddr == wdt_pkg::watchdog_control_off
    |-> prdata[4:0] == ctl)
    else $error("control readback wrong");
  chk_irq_masked: assert property (
    msk == 2'h0 && $past(msk) == 2'h0 |-> !irq)
    else $error("irq with all masked");
  chk_irq_status: assert property (
    acc && !pwrite && paddr == st |-> irq == |(prdata[1:0] & $past(msk)))
    else $error("irq disagrees with status");
  chk_irq_clear: assert property (
    wr && paddr == st && pwdata[1:0] == 2'h3 |-> ##2 !irq)
    else $error("irq kept after clear");
  cover property ($rose(irq));
  cover property ($rose(system_reset));
  cover property (wr && paddr == arm && pwdata == 32'h0000_00aa);
endmodule : wdt_asserts
bind watchdog_and_periodic_tick wdt_asserts i_wdt_asserts (.mclk, .resetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .pseudo_stop, .irq, .system_reset);
`default_nettype wire

// [tb/tb_top.sv]
/* self-checking bench for the watchdog and periodic tick block.
   assumes the bench drives apb and pseudo_stop itself; one mclk. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0]  ctl_a = wdt_pkg::watchdog_control_off;
  localparam logic [7:0]  arm_a = wdt_pkg::watchdog_arm_register_off;
  localparam logic [7:0]  rtc_a = wdt_pkg::periodic_rate_control_off;
  localparam logic [7:0]  st_a  = wdt_pkg::status_off;
  localparam logic [7:0]  msk_a = wdt_pkg::mask_off;
  localparam logic [31:0] one   = 32'h0000_0001;
  logic        mclk, resetn, psel, penable, pwrite, pseudo_stop, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, irq, system_reset;
  logic        sr_q = 1'b0;
  int          mismatches, num_checks, trips, cyc, t0;
  watchdog_and_periodic_tick i_watchdog_and_periodic_tick (.mclk, .resetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pseudo_stop, .irq, .system_reset);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // run needs about 9700 cycles
  always @(posedge mclk) begin
    sr_q <= system_reset;
    if (system_reset === 1'b1 && !sr_q) trips++;
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t %s: %h vs %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic pause(input int n);
    repeat (n) @(posedge mclk);
  endtask : pause
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : xfer
  task automatic service();
    xfer(arm_a, 1'b1, 32'h0000_0055);
    xfer(arm_a, 1'b1, 32'h0000_00aa);
  endtask : service
  task automatic t_reset();
    xfer(ctl_a, 1'b0, '0);
    chk(rd, '0, "control reset");
    xfer(rtc_a, 1'b0, '0);
    chk(rd, '0, "rate reset");
    xfer(8'h18, 1'b0, '0);
    chk(32'(err), one, "unmapped error");
    xfer(arm_a, 1'b1, 32'h0000_0033);
    pause(20);
    chk(trips, '0, "arm ignored while off");
    $display("test reset done");
  endtask : t_reset
  task automatic t_tick();
    // 16 oscillator ticks, 64 mclk
    xfer(rtc_a, 1'b1, 32'h0000_0010);
    pause(40);
    xfer(rtc_a, 1'b1, 32'h0000_0010);
    pause(40);
    xfer(st_a, 1'b0, '0);
    chk(rd, '0, "period restarted");
    pause(30);
    xfer(st_a, 1'b0, '0);
    chk(rd, one, "flag set");
    chk(32'(irq), '0, "irq masked");
    xfer(msk_a, 1'b1, one);
    pause(3);
    chk(32'(irq), one, "irq raised");
    xfer(st_a, 1'b1, 32'h0000_0003);
    pause(2);
    chk(32'(irq), '0, "irq cleared");
    pause(60);
    chk(32'(irq), one, "next period");
    xfer(rtc_a, 1'b1, '0);
    xfer(st_a, 1'b1, one);
    pause(150);
    xfer(st_a, 1'b0, '0);
    chk(rd, '0, "tick stopped");
    xfer(msk_a, 1'b1, '0);
    $display("test tick done");
  endtask : t_tick
  task automatic t_service();
    t0 = trips;
    // rate 1: 256 oscillator ticks, 1024 mclk
    xfer(ctl_a, 1'b1, one);
    repeat (3) begin
      pause(700);
      service();
    end
    pause(900);
    chk(trips - t0, '0, "serviced");
    pause(200);
    chk(trips - t0, one, "expired");
    xfer(ctl_a, 1'b1, 32'h0000_0002);
    pause(1500);
    chk(trips - t0, one, "rate two longer");
    pause(700);
    chk(trips - t0, 32'h0000_0002, "rate two expired");
    xfer(ctl_a, 1'b1, 32'h0000_0001);
    xfer(arm_a, 1'b1, 32'h0000_0012);
    pause(3);
    chk(trips - t0, 32'h0000_0003, "bad arm value");
    xfer(ctl_a, 1'b1, '0);
    xfer(st_a, 1'b0, '0);
    chk(rd, 32'h0000_0002, "trip recorded");
    xfer(st_a, 1'b1, 32'h0000_0003);
    xfer(st_a, 1'b0, '0);
    chk(rd, '0, "trip flag cleared");
    $display("test service done");
  endtask : t_service
  task automatic t_window();
    t0 = trips;
    xfer(ctl_a, 1'b1, 32'h0000_0009);
    xfer(arm_a, 1'b1, 32'h0000_0055);
    pause(3);
    chk(trips - t0, one, "early service");
    xfer(ctl_a, 1'b1, '0);
    xfer(ctl_a, 1'b1, 32'h0000_0009);
    pause(850);
    service();
    pause(700);
    chk(trips - t0, one, "window service");
    xfer(ctl_a, 1'b1, '0);
    pseudo_stop <= 1'b1;
    xfer(ctl_a, 1'b1, one);
    pause(1200);
    chk(trips - t0, one, "halted in pseudo-stop");
    xfer(ctl_a, 1'b1, 32'h0000_0011);
    pause(1100);
    chk(trips - t0, 32'h0000_0002, "runs in pseudo-stop");
    xfer(ctl_a, 1'b1, '0);
    pseudo_stop <= 1'b0;
    $display("test window done");
  endtask : t_window
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial begin
    {psel, penable, pwrite, pseudo_stop} = 4'h0;
    paddr = '0;
    pwdata = '0;
    resetn = 1'b0;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_tick();
    t_service();
    t_window();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
